// ===== core/fault_pkg.sv
// Contract
// - a faulted channel-B output is forced off and, under auto restart (default), retried.
// - under restart-after-reset a faulted output waits for an inactive, then an active command.
// - each rising output edge masks its faults for the filter window, 0..255 ms, default 80 ms.
// - a channel-B output fault yields a channel diagnostic with port number 1..8 and code 0x1810.
// - the port's red fault indicator is on while an output fault stands.
// - a port in communication mode flags device removed, wrong device or line fault.
// - with the removal alarm enabled (default) that error goes out as a submodule-pulled alarm.
// - with the removal alarm off and port diagnostics on it goes out as code 0x1800 on the port.
// - a communication port without device blinks its green indicator and keeps its red one off.
// - a bad parameter write yields channel 0x8000 code 0x0010.
// - an inconsistent bit-mapping block yields code 0x011A.
// - a data length mismatch yields code 0x17FF when the length policy allows it.
// - active forcing yields code 0x000A.
// - an internal abnormal state yields code 0x0009.
package fault_pkg;
    localparam int NPORT = 8;
    localparam int NMASTER = 5;
    // timing
    localparam int CLK_NS = 20;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_NS;
    localparam logic [7:0] FILTER_RST_MS = 8'h50;
    localparam logic [7:0] RESTART_MS = 8'h64;
    localparam logic [7:0] BLINK_MS = 8'hFA;
    // register offsets
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_FILTER = 12'h004;
    localparam logic [11:0] OFF_COMMODE = 12'h008;
    localparam logic [11:0] OFF_STATUS = 12'h00C;
    localparam logic [11:0] OFF_IRQ_STAT = 12'h010;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h014;
    // control bits
    localparam int CTRL_RESTART = 0;
    localparam int CTRL_PULL = 1;
    localparam int CTRL_PDIAG = 2;
    localparam int CTRL_LEN = 3;
    localparam logic [3:0] CTRL_RST = 4'hE;
    // interrupt status layout
    localparam int IRQ_OUT_LSB = 0;
    localparam int IRQ_COM_LSB = 8;
    localparam int IRQ_M_LSB = 16;
    localparam int IRQ_W = 21;
    // diagnostic codes
    localparam logic [15:0] CHAN_MASTER = 16'h8000;
    localparam logic [15:0] CODE_BOUT = 16'h1810;
    localparam logic [15:0] CODE_NODEV = 16'h1800;
    localparam logic [15:0] CODE_PULL = 16'h0000;
    // master events: 0 param, 1 mapping, 2 length, 3 forcing, 4 internal
    localparam logic [NMASTER-1:0][15:0] MASTER_CODES =
        {16'h0009, 16'h000A, 16'h17FF, 16'h011A, 16'h0010};
endpackage

// ===== core/port_fault_diag.sv
`timescale 1ns/1ps
module port_fault_diag #(
    parameter int MS_CYCLES = fault_pkg::MS_CYCLES,
    parameter bit MASTER_FIRST = 1'b1
) (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // port pins
    input wire logic [fault_pkg::NPORT-1:0] OUT_CMD,
    input wire logic [fault_pkg::NPORT-1:0] B_FAULT,
    input wire logic [fault_pkg::NPORT-1:0] DEV_PRESENT,
    input wire logic [fault_pkg::NPORT-1:0] DEV_WRONG,
    input wire logic [fault_pkg::NPORT-1:0] LINE_FAULT,
    output logic [fault_pkg::NPORT-1:0] B_OUT,
    output logic [fault_pkg::NPORT-1:0] PORT_FAULT_LED,
    output logic [fault_pkg::NPORT-1:0] LINK_LED,
    // master-level conditions
    input wire logic PARAM_ERR,
    input wire logic MAP_ERR,
    input wire logic LEN_MISMATCH,
    input wire logic FORCE_ACTIVE,
    input wire logic INTERNAL_ERR,
    // diagnostic stream to controller
    output logic DIAG_VALID,
    input wire logic DIAG_READY,
    output logic [15:0] DIAG_CHAN,
    output logic [15:0] DIAG_CODE,
    output logic DIAG_PULL,
    // interrupt
    output logic IRQ
);
    import fault_pkg::*;

    typedef struct packed {
        logic [31:0] ms_cnt;
        logic ms_tick;
        logic [7:0] blink_cnt;
        logic blink;
        logic [3:0] ctrl;
        logic [7:0] filter_ms;
        logic [NPORT-1:0] com_mode;
        logic [NPORT-1:0] flt_s1, flt_s2, pres_s1, pres_s2;
        logic [NPORT-1:0] wrong_s1, wrong_s2, line_s1, line_s2;
        logic [NPORT-1:0] drv, trip, com_err;
        logic [NPORT-1:0][7:0] filt;
        logic [NPORT-1:0][7:0] retry;
        logic [NPORT-1:0] pend_out, pend_pull, pend_nodev;
        logic [NMASTER-1:0] pend_m, m_prev;
        logic [IRQ_W-1:0] irq_stat, irq_mask;
        logic [31:0] rdata;
        logic slverr;
        logic dv;
        logic [15:0] dchan, dcode;
        logic dpull;
    } state_t;

    state_t st, n;

    always_comb begin
        logic [NPORT-1:0] ev_out, ev_com;
        logic [NMASTER-1:0] m_now, ev_m;
        logic found_m, found_p;
        logic [2:0] idx_m, idx_p;
        logic [1:0] kind_p;
        ev_out = '0;
        ev_com = '0;
        found_m = 1'b0;
        found_p = 1'b0;
        idx_m = '0;
        idx_p = '0;
        kind_p = '0;
        m_now = '0;
        ev_m = '0;
        n = st;
        // fault, presence, wrong-device and line pins pass two flops before use
        n.flt_s1 = B_FAULT;
        n.flt_s2 = st.flt_s1;
        n.pres_s1 = DEV_PRESENT;
        n.pres_s2 = st.pres_s1;
        n.wrong_s1 = DEV_WRONG;
        n.wrong_s2 = st.wrong_s1;
        n.line_s1 = LINE_FAULT;
        n.line_s2 = st.line_s1;
        // millisecond time base shared by all ports
        n.ms_tick = 1'b0;
        if (st.ms_cnt == 32'(MS_CYCLES - 1)) begin
            n.ms_cnt = '0;
            n.ms_tick = 1'b1;
        end else begin
            n.ms_cnt = st.ms_cnt + 32'd1;
        end
        if (st.ms_tick) begin
            if (st.blink_cnt == BLINK_MS - 8'd1) begin
                n.blink_cnt = '0;
                n.blink = ~st.blink;
            end else begin
                n.blink_cnt = st.blink_cnt + 8'd1;
            end
        end
        for (int p = 0; p < NPORT; p++) begin
            if (st.trip[p]) begin
                if (st.ctrl[CTRL_RESTART]) begin
                    if (!OUT_CMD[p]) begin
                        n.trip[p] = 1'b0;
                    end
                end else if (st.ms_tick) begin
                    if (st.retry[p] == RESTART_MS - 8'd1) begin
                        n.trip[p] = 1'b0;
                        n.retry[p] = '0;
                    end else begin
                        n.retry[p] = st.retry[p] + 8'd1;
                    end
                end
            end else if (st.drv[p] && st.flt_s2[p] && st.filt[p] == 8'h00) begin
                n.trip[p] = 1'b1;
                n.retry[p] = '0;
                ev_out[p] = 1'b1;
            end
            n.drv[p] = OUT_CMD[p] & ~n.trip[p] & ~st.com_mode[p];
            if (n.drv[p] && !st.drv[p]) begin
                n.filt[p] = st.filter_ms;
            end else if (st.ms_tick && st.filt[p] != 8'h00) begin
                n.filt[p] = st.filt[p] - 8'd1;
            end
            n.com_err[p] = st.com_mode[p] & (~st.pres_s2[p] | st.wrong_s2[p] | st.line_s2[p]);
            ev_com[p] = n.com_err[p] & ~st.com_err[p];
        end
        m_now = {INTERNAL_ERR, FORCE_ACTIVE, LEN_MISMATCH & st.ctrl[CTRL_LEN], MAP_ERR, PARAM_ERR};
        ev_m = m_now & ~st.m_prev;
        n.m_prev = m_now;
        for (int i = NMASTER - 1; i >= 0; i--) begin
            if (st.pend_m[i]) begin
                found_m = 1'b1;
                idx_m = 3'(i);
            end
        end
        for (int p = NPORT - 1; p >= 0; p--) begin
            if (st.pend_out[p] | st.pend_pull[p] | st.pend_nodev[p]) begin
                found_p = 1'b1;
                idx_p = 3'(p);
                kind_p = st.pend_out[p] ? 2'd0 : (st.pend_pull[p] ? 2'd1 : 2'd2);
            end
        end
        if (st.dv && DIAG_READY) begin
            n.dv = 1'b0;
        end
        if (!n.dv) begin
            // order between master and port messages
            if (found_m && (MASTER_FIRST || !found_p)) begin
                n.dv = 1'b1;
                n.dchan = CHAN_MASTER;
                n.dcode = MASTER_CODES[idx_m];
                n.dpull = 1'b0;
                n.pend_m[idx_m] = 1'b0;
            end else if (found_p) begin
                n.dv = 1'b1;
                n.dchan = 16'(idx_p) + 16'h0001;
                n.dpull = (kind_p == 2'd1);
                if (kind_p == 2'd0) begin
                    n.dcode = CODE_BOUT;
                    n.pend_out[idx_p] = 1'b0;
                end else if (kind_p == 2'd1) begin
                    n.dcode = CODE_PULL;
                    n.pend_pull[idx_p] = 1'b0;
                end else begin
                    n.dcode = CODE_NODEV;
                    n.pend_nodev[idx_p] = 1'b0;
                end
            end
        end
        // new events are set after the clear so none is lost
        n.pend_out = n.pend_out | ev_out;
        n.pend_m = n.pend_m | ev_m;
        if (st.ctrl[CTRL_PULL]) begin
            n.pend_pull = n.pend_pull | ev_com;
        end else if (st.ctrl[CTRL_PDIAG]) begin
            n.pend_nodev = n.pend_nodev | ev_com;
        end
        // apb: decode in setup so read data is a flop in the access phase
        if (PSEL && !PENABLE) begin
            n.slverr = 1'b0;
            if (PADDR == OFF_CTRL) begin
                n.rdata = {28'h000_0000, st.ctrl};
            end else if (PADDR == OFF_FILTER) begin
                n.rdata = {24'h00_0000, st.filter_ms};
            end else if (PADDR == OFF_COMMODE) begin
                n.rdata = {24'h00_0000, st.com_mode};
            end else if (PADDR == OFF_STATUS) begin
                n.rdata = {16'h0000, st.com_err, st.trip};
            end else if (PADDR == OFF_IRQ_STAT) begin
                n.rdata = {11'h000, st.irq_stat};
            end else if (PADDR == OFF_IRQ_MASK) begin
                n.rdata = {11'h000, st.irq_mask};
            end else begin
                n.rdata = '0;
                n.slverr = 1'b1;
            end
        end
        if (PSEL && PENABLE && PWRITE) begin
            if (PADDR == OFF_CTRL) begin
                n.ctrl = PWDATA[3:0];
            end else if (PADDR == OFF_FILTER) begin
                n.filter_ms = PWDATA[7:0];
            end else if (PADDR == OFF_COMMODE) begin
                n.com_mode = PWDATA[7:0];
            end else if (PADDR == OFF_IRQ_STAT) begin
                n.irq_stat = st.irq_stat & ~PWDATA[IRQ_W-1:0];
            end else if (PADDR == OFF_IRQ_MASK) begin
                n.irq_mask = PWDATA[IRQ_W-1:0];
            end
        end
        n.irq_stat[IRQ_OUT_LSB +: NPORT] = n.irq_stat[IRQ_OUT_LSB +: NPORT] | ev_out;
        n.irq_stat[IRQ_COM_LSB +: NPORT] = n.irq_stat[IRQ_COM_LSB +: NPORT] | ev_com;
        n.irq_stat[IRQ_M_LSB +: NMASTER] = n.irq_stat[IRQ_M_LSB +: NMASTER] | ev_m;
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            st <= '0;
            st.ctrl <= CTRL_RST;
            st.filter_ms <= FILTER_RST_MS;
        end else begin
            st <= n;
        end
    end

    assign PRDATA = st.rdata;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL & PENABLE & st.slverr;
    assign B_OUT = st.drv;
    assign PORT_FAULT_LED = st.trip & ~st.com_mode;
    // blink when no device, red stays off
    assign LINK_LED = st.com_mode & (st.pres_s2 | {NPORT{st.blink}});
    assign DIAG_VALID = st.dv;
    assign DIAG_CHAN = st.dchan;
    assign DIAG_CODE = st.dcode;
    assign DIAG_PULL = st.dpull;
    assign IRQ = |(st.irq_stat & st.irq_mask);

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    a_trip_drive_off: assert property (
        (st.trip & st.drv) == '0) else $error("tripped output still driven");
    a_auto_retry: assert property (
        !st.ctrl[CTRL_RESTART] && st.trip[0] && st.ms_tick && st.retry[0] == RESTART_MS - 8'd1
        |=> !st.trip[0]) else $error("automatic retry missed");
    a_reset_hold: assert property (
        st.ctrl[CTRL_RESTART] && st.trip[0] && OUT_CMD[0] |=> st.trip[0])
        else $error("output released while still commanded");
    a_filter_load: assert property (
        $rose(st.drv[0]) |-> st.filt[0] == $past(st.filter_ms)) else $error("filter not loaded");
    a_filter_mask: assert property (
        st.filt[0] != 8'h00 |=> !$rose(st.trip[0])) else $error("fault seen inside window");
    a_bout_chan: assert property (
        DIAG_VALID && DIAG_CODE == CODE_BOUT |-> DIAG_CHAN >= 16'h0001 && DIAG_CHAN <= 16'h0008)
        else $error("bad output fault channel");
    a_red_led: assert property (
        st.drv[0] && st.flt_s2[0] && st.filt[0] == 8'h00 |=> PORT_FAULT_LED[0] || st.com_mode[0])
        else $error("red indicator off");
    a_nodev_gate: assert property (
        DIAG_VALID && DIAG_CODE == CODE_NODEV && !DIAG_PULL && !$past(DIAG_VALID && !DIAG_READY)
        |-> $past(st.pend_nodev) != '0) else $error("no device code without cause");
    a_com_red_off: assert property (
        st.com_mode[0] |-> !PORT_FAULT_LED[0]) else $error("red on for com port");
    a_param_pend: assert property (
        PARAM_ERR && !st.m_prev[0] |=> st.pend_m[0] || (DIAG_VALID && DIAG_CODE == 16'h0010))
        else $error("parameter error lost");
    a_diag_hold: assert property (
        DIAG_VALID && !DIAG_READY |=> DIAG_VALID && $stable(DIAG_CODE) && $stable(DIAG_CHAN))
        else $error("diagnostic dropped before taken");

    c_out_fault: cover property ($rose(st.trip[0]));
    c_pull_alarm: cover property (DIAG_VALID && DIAG_PULL);
    c_master_diag: cover property (DIAG_VALID && DIAG_CHAN == CHAN_MASTER);
endmodule

// ===== testbench/diag_sink.sv
`timescale 1ns/1ps
module diag_sink (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // diagnostic stream
    input wire logic valid,
    input wire logic [15:0] chan,
    input wire logic [15:0] code,
    input wire logic pull,
    output logic ready,
    // control and capture
    input wire logic slow,
    output logic [15:0] got_chan,
    output logic [15:0] got_code,
    output logic got_pull,
    output logic [7:0] cnt
);
    logic [1:0] ph;
    // slow mode takes one message in four cycles, so valid must stand meanwhile
    assign ready = !slow || ph == 2'd3;
    always_ff @(posedge clk) begin
        if (rst) begin
            ph <= 2'd0;
            cnt <= 8'h00;
            got_chan <= 16'h0000;
            got_code <= 16'h0000;
            got_pull <= 1'b0;
        end else begin
            ph <= ph + 2'd1;
            if (valid && ready) begin
                got_chan <= chan;
                got_code <= code;
                got_pull <= pull;
                cnt <= cnt + 8'h01;
            end
        end
    end
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
    $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module testbench;
    import fault_pkg::*;
    logic CORE_CLK, RST, PSEL, PENABLE, PWRITE, DIAG_READY, DIAG_VALID, DIAG_PULL, IRQ;
    logic PREADY, PSLVERR, got_pull, slow;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd;
    logic [7:0] OUT_CMD, B_FAULT, DEV_PRESENT, DEV_WRONG, LINE_FAULT, B_OUT, RLED, GLED;
    logic [7:0] cnt, mark;
    logic [4:0] mev;
    logic [15:0] DIAG_CHAN, DIAG_CODE, got_chan, got_code;
    logic er;
    int n_fail = 0;
    int checked = 0;
    logic [15:0] codes[5] = '{16'h0010, 16'h011A, 16'h17FF, 16'h000A, 16'h0009};

    port_fault_diag #(.MS_CYCLES(10)) u_dut (.CORE_CLK(CORE_CLK), .RST(RST), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .OUT_CMD(OUT_CMD), .B_FAULT(B_FAULT),
        .DEV_PRESENT(DEV_PRESENT), .DEV_WRONG(DEV_WRONG), .LINE_FAULT(LINE_FAULT),
        .B_OUT(B_OUT), .PORT_FAULT_LED(RLED), .LINK_LED(GLED), .PARAM_ERR(mev[0]),
        .MAP_ERR(mev[1]), .LEN_MISMATCH(mev[2]), .FORCE_ACTIVE(mev[3]),
        .INTERNAL_ERR(mev[4]), .DIAG_VALID(DIAG_VALID), .DIAG_READY(DIAG_READY),
        .DIAG_CHAN(DIAG_CHAN), .DIAG_CODE(DIAG_CODE), .DIAG_PULL(DIAG_PULL), .IRQ(IRQ));
    diag_sink u_sink (.clk(CORE_CLK), .rst(RST), .valid(DIAG_VALID), .chan(DIAG_CHAN),
        .code(DIAG_CODE), .pull(DIAG_PULL), .ready(DIAG_READY), .slow(slow),
        .got_chan(got_chan), .got_code(got_code), .got_pull(got_pull), .cnt(cnt));

    initial begin
        CORE_CLK = 1'b0;
        forever #10 CORE_CLK = ~CORE_CLK;
    end

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge CORE_CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CORE_CLK);
        PENABLE <= 1'b1;
        // only the watchdog ends a wait for the slave
        do begin
            @(posedge CORE_CLK);
        end while (PREADY !== 1'b1);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    // waits for the sink to take a message that arrived after mark was set
    task automatic expect_diag(input logic [15:0] ch, input logic [15:0] cd, input logic pl);
        int k;
        k = 0;
        while (cnt === mark && k < 3000) begin
            @(posedge CORE_CLK);
            k++;
        end
        `CHK(k < 3000, 1'b1)
        `CHK(got_chan, ch)
        `CHK(got_code, cd)
        `CHK(got_pull, pl)
    endtask

    task automatic wait_bit(input int b, input int lim);
        int k;
        k = 0;
        while (B_OUT[b] !== 1'b1 && k < lim) begin @(posedge CORE_CLK); k++; end
    endtask

    task automatic t_regs();
        apb(1'b0, 12'h000, 32'h0000_0000);
        `CHK(rd, 32'h0000_000E)
        apb(1'b0, 12'h004, 32'h0000_0000);
        `CHK(rd, 32'h0000_0050)
        apb(1'b0, 12'h020, 32'h0000_0000);
        `CHK(er, 1'b1)
    endtask

    task automatic t_master();
        slow <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            mark = cnt;
            mev[i] <= 1'b1;
            expect_diag(16'h8000, codes[i], 1'b0);
            mev[i] <= 1'b0;
        end
        slow <= 1'b0;
        // length mismatch stays silent while its diagnostic is off
        apb(1'b1, 12'h000, 32'h0000_0006);
        mark = cnt;
        mev[2] <= 1'b1;
        repeat (20) @(posedge CORE_CLK);
        `CHK(cnt, mark)
        mev[2] <= 1'b0;
        apb(1'b1, 12'h000, 32'h0000_000E);
    endtask

    task automatic t_out_auto();
        apb(1'b1, 12'h004, 32'h0000_0002);
        B_FAULT[0] <= 1'b1;
        OUT_CMD[0] <= 1'b1;
        mark = cnt;
        repeat (10) @(posedge CORE_CLK);
        `CHK(B_OUT[0], 1'b1)
        expect_diag(16'h0001, 16'h1810, 1'b0);
        `CHK(B_OUT[0], 1'b0)
        `CHK(RLED[0], 1'b1)
        B_FAULT[0] <= 1'b0;
        wait_bit(0, 1200);
        `CHK(B_OUT[0], 1'b1)
    endtask

    task automatic t_out_reset();
        apb(1'b1, 12'h000, 32'h0000_000F);
        apb(1'b1, 12'h004, 32'h0000_0000);
        OUT_CMD[1] <= 1'b1;
        repeat (4) @(posedge CORE_CLK);
        mark = cnt;
        B_FAULT[1] <= 1'b1;
        expect_diag(16'h0002, 16'h1810, 1'b0);
        B_FAULT[1] <= 1'b0;
        repeat (1200) @(posedge CORE_CLK);
        `CHK(B_OUT[1], 1'b0)
        apb(1'b0, 12'h00C, 32'h0000_0000);
        `CHK(rd[1], 1'b1)
        OUT_CMD[1] <= 1'b0;
        repeat (3) @(posedge CORE_CLK);
        OUT_CMD[1] <= 1'b1;
        wait_bit(1, 20);
        `CHK(B_OUT[1], 1'b1)
    endtask

    task automatic t_com();
        logic l0;
        apb(1'b1, 12'h000, 32'h0000_000E);
        DEV_PRESENT <= 8'hFB;
        mark = cnt;
        apb(1'b1, 12'h008, 32'h0000_0004);
        expect_diag(16'h0003, 16'h0000, 1'b1);
        `CHK(RLED[2], 1'b0)
        l0 = GLED[2];
        for (int k = 0; k < 2600 && GLED[2] === l0; k++) @(posedge CORE_CLK);
        `CHK(GLED[2], ~l0)
        apb(1'b1, 12'h000, 32'h0000_000C);
        mark = cnt;
        DEV_WRONG <= 8'h08;
        apb(1'b1, 12'h008, 32'h0000_000C);
        expect_diag(16'h0004, 16'h1800, 1'b0);
        mark = cnt;
        LINE_FAULT <= 8'h20;
        apb(1'b1, 12'h008, 32'h0000_002C);
        expect_diag(16'h0006, 16'h1800, 1'b0);
    endtask

    task automatic t_irq();
        `CHK(IRQ, 1'b0)
        apb(1'b1, 12'h014, 32'h001F_0000);
        @(posedge CORE_CLK);
        `CHK(IRQ, 1'b1)
        apb(1'b1, 12'h010, 32'h001F_0000);
        repeat (2) @(posedge CORE_CLK);
        `CHK(IRQ, 1'b0)
        apb(1'b0, 12'h010, 32'h0000_0000);
        `CHK(rd[20:16], 5'h00)
    endtask

    task automatic finish_test();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        RST = 1'b1;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 12'h000;
        PWDATA = 32'h0000_0000;
        OUT_CMD = 8'h00;
        B_FAULT = 8'h00;
        DEV_PRESENT = 8'hFF;
        DEV_WRONG = 8'h00;
        LINE_FAULT = 8'h00;
        mev = 5'h00;
        slow = 1'b0;
        repeat (8) @(posedge CORE_CLK);
        RST <= 1'b0;
        t_regs();
        t_master();
        t_out_auto();
        t_out_reset();
        t_com();
        t_irq();
        finish_test();
    end

    initial begin
        #(40000 * 20);
        n_fail++;
        finish_test();
    end
endmodule
